/* File: ftak_addr_store.v */
// Address storage with no reset, holding the target address fields
`timescale 1ns/1ps
`default_nettype none
module ftak_addr_store
#(
   parameter HIGH_WIDTH = 8,
   parameter LOW_WIDTH = 16
)
(
   input wire clock,
   input wire writeHigh,
   input wire writeLow,
   input wire [3:0] byteSel,
   input wire [31:0] writeData,
   output reg [HIGH_WIDTH-1:0] highField,
   output reg [LOW_WIDTH-1:0] lowField
);
   // Upper field, low byte lane only, no reset value
   always @(posedge clock)
   begin
      if (writeHigh && byteSel[0])
      begin
         highField <= writeData[HIGH_WIDTH-1:0];
      end
   end

   // Lower field, per byte lane, no reset value
   genvar lane;
   generate
      for (lane = 0; lane < LOW_WIDTH/8; lane = lane + 1)
      begin : gLane
         always @(posedge clock)
         begin
            if (writeLow && byteSel[lane])
            begin
               lowField[lane*8 +: 8] <= writeData[lane*8 +: 8];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* File: ftak_defines.vh */
// Constants for the flash target address and unlock key register slice
// Operation
// - The upper address register holds an 8-bit field that supplies bits 23 to 16 of the flash target address.
// - The lower address register holds 16 bits that supply bits 15 to 0 of the flash target address.
// - Both address registers are readable and writable by software and have no defined reset value.
// - Bits 15 to 8 of the upper address and key registers are unimplemented, ignore writes and read as zero.
// - The key register holds a write-only 8-bit field in bits 7 to 0, zero after reset, that reads back nothing.
`ifndef FTAK_DEFINES_VH
`define FTAK_DEFINES_VH
`define FTAK_ADDR_HIGH_OFFSET 4'h0
`define FTAK_ADDR_LOW_OFFSET 4'h4
`define FTAK_KEY_OFFSET 4'h8
`define FTAK_HIGH_FIELD_WIDTH 8
`define FTAK_LOW_FIELD_WIDTH 16
`define FTAK_KEY_FIELD_WIDTH 8
`define FTAK_KEY_RESET 8'h00
`define FTAK_UNMAPPED_READ 32'h00000000
`endif

/* File: ftak_regs.v */
// Wishbone slave for the flash target address and unlock key registers
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "ftak_defines.vh"
module ftak_regs
#(
   parameter HIGH_WIDTH = `FTAK_HIGH_FIELD_WIDTH,
   parameter LOW_WIDTH = `FTAK_LOW_FIELD_WIDTH,
   parameter KEY_WIDTH = `FTAK_KEY_FIELD_WIDTH
)
(
   input wire clock,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg [HIGH_WIDTH+LOW_WIDTH-1:0] flashTargetAddress,
   output reg [KEY_WIDTH-1:0] flashUnlockKey,
   output reg keyWriteStrobe
);
   // Offsets and constant answers; high and key fields fit in lane 0
   localparam [3:0] OFF_HIGH = `FTAK_ADDR_HIGH_OFFSET;
   localparam [3:0] OFF_LOW = `FTAK_ADDR_LOW_OFFSET;
   localparam [3:0] OFF_KEY = `FTAK_KEY_OFFSET;
   localparam [31:0] ZERO_READ = `FTAK_UNMAPPED_READ;
   localparam [KEY_WIDTH-1:0] KEY_RESET = `FTAK_KEY_RESET;

   // Reset release flops
   reg rstSync1;
   reg rstSync2;

   // Stored address fields
   wire [HIGH_WIDTH-1:0] highField;
   wire [LOW_WIDTH-1:0] lowField;

   // Access qualifiers
   wire request;
   wire writeAccess;
   wire readAccess;

   // Offset hits
   wire hitHigh;
   wire hitLow;
   wire hitKey;

   // Write enables
   wire writeHigh;
   wire writeLow;
   wire writeKey;

   // Next values of the registered outputs
   reg [31:0] next_readData;
   reg [31:0] next_dataOut;
   reg next_ack;
   reg [KEY_WIDTH-1:0] next_key;
   reg next_strobe;

   // Reset release through two flops
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstSync1 <= 1'h0;
         rstSync2 <= 1'h0;
      end
      else
      begin
         rstSync1 <= 1'h1;
         rstSync2 <= rstSync1;
      end
   end

   // One access per ack; a held strobe is not taken twice
   assign request = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign writeAccess = request && wb_we_i;
   assign readAccess = request && !wb_we_i;

   // Address match against the three offsets
   assign hitHigh = (wb_adr_i == OFF_HIGH);
   assign hitLow = (wb_adr_i == OFF_LOW);
   assign hitKey = (wb_adr_i == OFF_KEY);

   // Write enables; the key only takes lane 0
   assign writeHigh = writeAccess && hitHigh;
   assign writeLow = writeAccess && hitLow;
   assign writeKey = writeAccess && hitKey && wb_sel_i[0];

   // Address fields without reset
   ftak_addr_store #(
      .HIGH_WIDTH(HIGH_WIDTH),
      .LOW_WIDTH(LOW_WIDTH)
   ) uStore (
      .clock(clock),
      .writeHigh(writeHigh),
      .writeLow(writeLow),
      .byteSel(wb_sel_i),
      .writeData(wb_dat_i),
      .highField(highField),
      .lowField(lowField)
   );

   // Read mux; key and unmapped offsets read zero
   always @*
   begin
      next_readData = ZERO_READ;
      case (wb_adr_i)
         OFF_HIGH:
         begin
            next_readData[HIGH_WIDTH-1:0] = highField;
         end
         OFF_LOW:
         begin
            next_readData[LOW_WIDTH-1:0] = lowField;
         end
         OFF_KEY:
         begin
            next_readData = ZERO_READ;
         end
         default:
         begin
            next_readData = ZERO_READ;
         end
      endcase
   end

   // Ack follows each taken request by one cycle
   always @*
   begin
      next_ack = request;
   end

   // Read data only in the ack of a read, else zero
   always @*
   begin
      next_dataOut = ZERO_READ;
      if (readAccess)
      begin
         next_dataOut = next_readData;
      end
   end

   // Key keeps its value unless written
   always @*
   begin
      next_key = flashUnlockKey;
      if (writeKey)
      begin
         next_key = wb_dat_i[KEY_WIDTH-1:0];
      end
   end

   // Strobe only for a key write
   always @*
   begin
      next_strobe = 1'h0;
      if (writeKey)
      begin
         next_strobe = 1'h1;
      end
   end

   // Ack register
   always @(posedge clock or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         wb_ack_o <= 1'h0;
      end
      else
      begin
         wb_ack_o <= next_ack;
      end
   end

   // Read data register
   always @(posedge clock or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         wb_dat_o <= ZERO_READ;
      end
      else
      begin
         wb_dat_o <= next_dataOut;
      end
   end

   // Key register, zero out of reset
   always @(posedge clock or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         flashUnlockKey <= KEY_RESET;
      end
      else
      begin
         flashUnlockKey <= next_key;
      end
   end

   // Strobe pulse in the ack cycle of a key write
   always @(posedge clock or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         keyWriteStrobe <= 1'h0;
      end
      else
      begin
         keyWriteStrobe <= next_strobe;
      end
   end

   // Assembled target address, no reset like its sources
   always @(posedge clock)
   begin
      flashTargetAddress <= {highField, lowField};
   end
endmodule
`default_nettype wire

/* File: ftak_regs_chk.sv */
// Port checker for the flash address and key registers
`timescale 1ns/1ps
`default_nettype none
module ftak_regs_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic keyWriteStrobe,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic [23:0] flashTargetAddress,
   input wire logic [7:0] flashUnlockKey);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Ack cycle qualifiers
   wire logic wr = wb_ack_o && wb_we_i, rd = wb_ack_o && !wb_we_i;
   wire logic hi = wb_adr_i == 4'h0, lo = wb_adr_i == 4'h4, ky = wb_adr_i == 4'h8;
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack");
   property p_hi; wr && hi && wb_sel_i[0] |=> flashTargetAddress[23:16] == $past(wb_dat_i[7:0]); endproperty
   a_hi: assert property (p_hi) else $error("high");
   property p_lo; wr && lo && &wb_sel_i[1:0] |=> flashTargetAddress[15:0] == $past(wb_dat_i[15:0]); endproperty
   a_lo: assert property (p_lo) else $error("low");
   property p_rh; rd && hi |-> wb_dat_o == {24'h0, flashTargetAddress[23:16]}; endproperty
   a_rh: assert property (p_rh) else $error("read high");
   property p_rk; rd && ky |-> wb_dat_o == 32'h0; endproperty
   a_rk: assert property (p_rk) else $error("read key");
   property p_ky; wr && ky && wb_sel_i[0] |-> keyWriteStrobe && flashUnlockKey == wb_dat_i[7:0]; endproperty
   a_ky: assert property (p_ky) else $error("key");
   property p_ks; keyWriteStrobe |-> wb_ack_o && wb_we_i && ky; endproperty
   a_ks: assert property (p_ks) else $error("strobe");
endmodule
bind ftak_regs ftak_regs_chk chk (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .keyWriteStrobe(keyWriteStrobe), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .flashTargetAddress(flashTargetAddress),
   .flashUnlockKey(flashUnlockKey));
`default_nettype wire

/* File: test_flash_target_address_and_key_regs.sv */
// Bench for the flash address and key registers
`timescale 1ns/1ps
`default_nettype none
module test_flash_target_address_and_key_regs;
   logic clock = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, keyWriteStrobe;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [23:0] flashTargetAddress;
   logic [7:0] flashUnlockKey;
   logic ks;
   int err_total = 0, n_tests = 0, n;
   ftak_regs dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .flashTargetAddress(flashTargetAddress), .flashUnlockKey(flashUnlockKey), .keyWriteStrobe(keyWriteStrobe));
   // 5 ns clock
   always #2.5 clock = ~clock;
   // Compare and count
   task chk(string s, logic [31:0] e, g);
      n_tests++;
      err_total += (g !== e);
      if (g !== e)
         $display("[FAIL] %s exp %h got %h", s, e, g);
   endtask
   // One classic cycle, then a gap
   task bus(logic w, logic [3:0] a, logic [31:0] d);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      @(posedge clock);
      for (n = 0; n < 50 && wb_ack_o !== 1'h1; n++) @(posedge clock);
      q = wb_dat_o;
      ks = keyWriteStrobe;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      chk("ack", 32'h1, 32'(wb_ack_o));
      if (n == 50)
         conclude;
      @(posedge clock);
   endtask
   // Address fields, a lane that misses the high byte
   task t_addr;
      bus(1, 4'h0, 32'h123456A5);
      wb_sel_i <= 4'hE;
      bus(1, 4'h0, 32'hFFFFFF00);
      wb_sel_i <= 4'hF;
      bus(1, 4'h4, 32'hFFFFBEEF);
      wb_sel_i <= 4'h2;
      bus(1, 4'h4, 32'h00001100);
      wb_sel_i <= 4'hF;
      bus(0, 4'h0, 32'h0);
      chk("high", 32'hA5, q);
      bus(0, 4'h4, 32'h0);
      chk("low", 32'h11EF, q);
      chk("addr", 32'hA511EF, 32'(flashTargetAddress));
   endtask
   // Write-only key and unmapped read
   task t_key;
      chk("keyRst", 32'h0, 32'(flashUnlockKey));
      bus(1, 4'h8, 32'hFFFFFF3C);
      chk("key", 32'h3C, 32'(flashUnlockKey));
      chk("strobe", 32'h1, 32'(ks));
      chk("strobeEnd", 32'h0, 32'(keyWriteStrobe));
      wb_sel_i <= 4'hE;
      bus(1, 4'h8, 32'hFFFFFF5A);
      wb_sel_i <= 4'hF;
      chk("keyLane", 32'h3C, 32'(flashUnlockKey));
      chk("noStrobe", 32'h0, 32'(ks));
      bus(0, 4'h8, 32'h0);
      chk("keyRead", 32'h0, q);
      bus(0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, q);
   endtask
   // Mid-run reset clears the key and the bus answer
   task t_reset;
      bus(1, 4'h8, 32'h000000C3);
      chk("keyBefore", 32'hC3, 32'(flashUnlockKey));
      rst_n <= 0;
      repeat (2) @(posedge clock);
      rst_n <= 1;
      repeat (3) @(posedge clock);
      chk("keyReset", 32'h0, 32'(flashUnlockKey));
      chk("ackReset", 32'h0, 32'(wb_ack_o));
   endtask
   // Verdict and end of run
   task conclude;
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Reset, then scenarios
   initial
   begin
      repeat (20) @(posedge clock);
      rst_n <= 1;
      repeat (3) @(posedge clock);
      t_key;
      t_reset;
      t_addr;
      conclude;
   end
endmodule
`default_nettype wire
